// file: pkg/lst_pkg.sv
// lst_pkg: constants, field layout and carrier types of the link self-test and i2c timing register bank.
// assumes a single 10 MHz clock domain and an axi4-lite master holding 32-bit aligned words.
// Overview of operation
// - output mode 00 no toggling, 01 alternating one/zero, 1x self-test data toggling.
// - with automatic receive clock set, oscillator frequency comes from control bits 5-4.
// - frequency codes: 00 50 MHz, 01 25 MHz, 10 10 MHz, 11 reserved.
// - pin-configuration bit 1 takes settings from pins, 0 from control bits 2-0.
// - on self-test enable, clock source is written to remote register 0x14.
// - control bit 0 enables self-test; it resets to zero.
// - read-only error count returns the port picked by the second port select.
// - as i2c controller, scl high lasts the high count in 50 ns units.
// - as i2c controller, scl low lasts the low count in 50 ns units.
// - default counts give at least 5 us with the oscillator at 26 MHz.
package lst_pkg;
  localparam int CLK_NS = 100;
  localparam int UNIT_NS = 50;
  localparam int NOM_OSC_MHZ = 20;
  localparam int FAST_OSC_MHZ = 26;
  localparam int MIN_SCL_NS = 5000;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h24;
  localparam logic [7:0] IDX_ERR = 8'h25;
  localparam logic [7:0] IDX_HIGH = 8'h26;
  localparam logic [7:0] IDX_LOW = 8'h27;
  localparam logic [7:0] IDX_DP2 = 8'h28;
  localparam logic [7:0] IDX_AUX = 8'h30;
  localparam logic [7:0] IDX_IST = 8'h31;
  localparam logic [7:0] IDX_ICLR = 8'h32;
  localparam logic [7:0] IDX_IEN = 8'h33;

  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] HIGH_RST = 8'h83;
  localparam logic [7:0] LOW_RST = 8'h84;
  localparam logic [7:0] DP2_RST = 8'h20;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] SCL_MIN = 8'h07;

  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_FREQ_LSB = 4;
  localparam int CTRL_PIN_BIT = 3;
  localparam int CTRL_CSRC_LSB = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam int AUX_AUTO_BIT = 5;
  localparam int AUX_PORT_BIT = 0;

  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_ALT = 2'h1;
  localparam logic [1:0] FREQ_50 = 2'h0;
  localparam logic [1:0] FREQ_25 = 2'h1;
  localparam logic [1:0] FREQ_10 = 2'h2;
  localparam logic [1:0] FREQ_RSV = 2'h3;

  localparam logic [7:0] REMOTE_CSRC_ADDR = 8'h14;

  localparam int IRQ_W = 4;
  localparam int IRQ_REMOTE_DONE = 0;
  localparam int IRQ_ERR_SAT = 1;
  localparam int IRQ_FREQ_RSV = 2;
  localparam int IRQ_SCL_MIN = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int ADDR_W = 8;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } lst_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lst_axi_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [1:0] clk_src;
  } lst_remote_wr_s;
endpackage

// file: logic/lst_unit_timer.sv
// lst_unit_timer: measures a length given in 50 ns units against the 100 ns clock.
// assumes start is a one-cycle request from logic on the same clock.
module lst_unit_timer
  import lst_pkg::*;
#(
  parameter int LEN_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  output logic busy,
  output logic done
);
  localparam int NS_W = LEN_W + 8;

  typedef struct packed {
    logic busy;
    logic [LEN_W-1:0] len;
    logic [NS_W-1:0] acc;
  } lst_tmr_s;

  lst_tmr_s st_reg;
  lst_tmr_s st_next;
  logic [NS_W-1:0] target_ns;

  // least time: the phase ends at the first edge where elapsed time reaches the target
  assign target_ns = NS_W'(st_reg.len) * NS_W'(UNIT_NS);
  assign done = st_reg.busy && ((st_reg.acc + NS_W'(CLK_NS)) >= target_ns);
  assign busy = st_reg.busy;

  always_comb begin
    st_next = st_reg;
    if (done) begin
      st_next.busy = 1'b0;
    end
    if (start) begin
      st_next.busy = 1'b1;
      st_next.acc = '0;
      st_next.len = len;
    end else if (st_reg.busy) begin
      st_next.acc = st_reg.acc + NS_W'(CLK_NS);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// file: logic/lst_selftest_regs.sv
// lst_selftest_regs: self-test control, error count, oscillator select and i2c scl timing registers.
// assumes an axi4-lite master on mclk, self-test pins from outside the clock domain,
// and port error pulses, remote write ready and i2c requests from logic on mclk.
//
// Decided for this implementation: the AXI4-Lite register port.
module lst_selftest_regs
  import lst_pkg::*;
#(
  parameter int PORTS = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire lst_axi_req_s axi_req,
  output lst_axi_rsp_s axi_rsp,
  output logic irq,
  input wire logic [2:0] selftest_pin_cfg,
  input wire logic [PORTS-1:0] port_err,
  output lst_remote_wr_s remote_wr,
  input wire logic remote_wr_ready,
  output logic selftest_active,
  output logic out_toggle_alt,
  output logic out_toggle_data,
  output logic rx_clk_auto,
  output logic [1:0] rx_clk_freq_sel,
  output logic [7:0] datapath_control_second,
  input wire logic i2c_ctl_en,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_setup_req,
  output logic sda_setup_wait,
  output logic scl_release
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] high_w;
    logic [7:0] low_w;
    logic [7:0] dp2;
    logic [7:0] aux;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic [PORTS-1:0][7:0] cnt;
    logic en_prev;
    logic rw_valid;
    logic [1:0] rw_src;
    logic scl_active;
    logic low_phase;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } lst_state_s;

  lst_state_s st_reg;
  lst_state_s st_next;

  logic [2:0] eff_cfg;
  logic eff_en;
  logic port_sel;
  logic wr_go;
  logic rd_go;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic scl_start;
  logic scl_busy;
  logic scl_done;
  logic [7:0] scl_len;
  logic next_low;
  logic setup_start;
  logic setup_busy;
  logic setup_done;

  // pin settings are synchronised; register settings apply directly
  assign eff_cfg = st_reg.ctrl[CTRL_PIN_BIT] ? st_reg.pin_s2 : st_reg.ctrl[2:0];
  assign eff_en = eff_cfg[CTRL_EN_BIT];
  assign port_sel = st_reg.aux[AUX_PORT_BIT];
  assign wr_go = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
  assign rd_go = axi_req.arvalid && !st_reg.rvalid;
  assign wr_idx = st_reg.awaddr[7:2];
  assign rd_idx = axi_req.araddr[7:2];

  // scl phases run back to back: each done restarts the timer for the opposite phase
  assign scl_start = i2c_ctl_en && (!scl_busy || scl_done);
  assign next_low = st_reg.scl_active && (scl_done ? !st_reg.low_phase : st_reg.low_phase);
  assign scl_len = next_low ? st_reg.low_w : st_reg.high_w;
  // a setup request that arrives while one is timing is dropped
  assign setup_start = sda_setup_req && !setup_busy;

  lst_unit_timer #(.LEN_W(8)) u_scl_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(scl_start),
    .len(scl_len),
    .busy(scl_busy),
    .done(scl_done)
  );

  lst_unit_timer #(.LEN_W(8)) u_setup_timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .start(setup_start),
    .len(st_reg.low_w),
    .busy(setup_busy),
    .done(setup_done)
  );

  always_comb begin
    logic [IRQ_W-1:0] set_v;
    logic [IRQ_W-1:0] clr_v;
    set_v = '0;
    clr_v = '0;
    st_next = st_reg;
    st_next.pin_s1 = selftest_pin_cfg;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.en_prev = eff_en;

    // error counters count only during a run and saturate at all ones
    for (int p = 0; p < PORTS; p++) begin
      if (eff_en && !st_reg.en_prev) begin
        st_next.cnt[p] = '0;
      end else if (eff_en && port_err[p] && st_reg.cnt[p] != 8'hff) begin
        st_next.cnt[p] = st_reg.cnt[p] + 8'h01;
        if (st_reg.cnt[p] == 8'hfe) begin
          set_v[IRQ_ERR_SAT] = 1'b1;
        end
      end
    end

    // forward the clock source to the remote side once per enable
    if (st_reg.rw_valid && remote_wr_ready) begin
      st_next.rw_valid = 1'b0;
      set_v[IRQ_REMOTE_DONE] = 1'b1;
    end
    if (eff_en && !st_reg.en_prev && !st_reg.rw_valid) begin
      st_next.rw_valid = 1'b1;
      st_next.rw_src = eff_cfg[2:1];
    end

    // scl generator phase tracking
    if (!i2c_ctl_en) begin
      st_next.scl_active = 1'b0;
      st_next.low_phase = 1'b0;
    end else if (scl_start) begin
      st_next.scl_active = 1'b1;
      st_next.low_phase = next_low;
    end

    // axi write channel: address and data are taken independently
    if (axi_req.awvalid && !st_reg.aw_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_reg.w_have && !st_reg.bvalid) begin
      st_next.w_have = 1'b1;
      st_next.wdata = axi_req.wdata[7:0];
      st_next.wstrb0 = axi_req.wstrb[0];
    end
    if (st_reg.bvalid && axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (wr_idx)
        IDX_CTRL[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.ctrl = st_reg.wdata;
            if (st_reg.wdata[CTRL_FREQ_LSB+:2] == FREQ_RSV) begin
              set_v[IRQ_FREQ_RSV] = 1'b1;
            end
          end
        end
        IDX_HIGH[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.high_w = st_reg.wdata;
            // the value is kept as written; the flag only warns software
            if (st_reg.wdata < SCL_MIN) begin
              set_v[IRQ_SCL_MIN] = 1'b1;
            end
          end
        end
        IDX_LOW[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.low_w = st_reg.wdata;
          end
        end
        IDX_DP2[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.dp2 = st_reg.wdata;
          end
        end
        IDX_AUX[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.aux = st_reg.wdata;
          end
        end
        IDX_ICLR[5:0]: begin
          if (st_reg.wstrb0) begin
            clr_v = st_reg.wdata[IRQ_W-1:0];
          end
        end
        IDX_IEN[5:0]: begin
          if (st_reg.wstrb0) begin
            st_next.ien = st_reg.wdata[IRQ_W-1:0];
          end
        end
        IDX_ERR[5:0], IDX_IST[5:0]: begin
          st_next.bresp = RESP_OKAY;
        end
        default: begin
          st_next.bresp = RESP_DECERR;
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    st_next.ist = (st_reg.ist & ~clr_v) | set_v;

    // axi read channel: answer one cycle after the address is taken
    if (st_reg.rvalid && axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = 8'h00;
      unique case (rd_idx)
        IDX_CTRL[5:0]: st_next.rdata = st_reg.ctrl;
        IDX_ERR[5:0]: st_next.rdata = st_reg.cnt[port_sel];
        IDX_HIGH[5:0]: st_next.rdata = st_reg.high_w;
        IDX_LOW[5:0]: st_next.rdata = st_reg.low_w;
        IDX_DP2[5:0]: st_next.rdata = st_reg.dp2;
        IDX_AUX[5:0]: st_next.rdata = st_reg.aux;
        IDX_IST[5:0]: st_next.rdata = 8'(st_reg.ist);
        IDX_ICLR[5:0]: st_next.rdata = 8'h00;
        IDX_IEN[5:0]: st_next.rdata = 8'(st_reg.ien);
        default: st_next.rresp = RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.high_w <= HIGH_RST;
      st_reg.low_w <= LOW_RST;
      st_reg.dp2 <= DP2_RST;
      st_reg.aux <= AUX_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // readies drop with ce so that no transfer is taken while the state is frozen
  assign axi_rsp.awready = ce && !st_reg.aw_have && !st_reg.bvalid;
  assign axi_rsp.wready = ce && !st_reg.w_have && !st_reg.bvalid;
  assign axi_rsp.bvalid = st_reg.bvalid;
  assign axi_rsp.bresp = st_reg.bresp;
  assign axi_rsp.arready = ce && !st_reg.rvalid;
  assign axi_rsp.rvalid = st_reg.rvalid;
  assign axi_rsp.rdata = {24'h000000, st_reg.rdata};
  assign axi_rsp.rresp = st_reg.rresp;

  assign irq = |(st_reg.ist & st_reg.ien);
  assign remote_wr.valid = st_reg.rw_valid;
  assign remote_wr.addr = REMOTE_CSRC_ADDR;
  assign remote_wr.clk_src = st_reg.rw_src;
  assign selftest_active = eff_en;
  // code 1x toggles from self-test data, 01 alternates, 00 holds still
  assign out_toggle_alt = (st_reg.ctrl[CTRL_MODE_LSB+:2] == MODE_ALT);
  assign out_toggle_data = st_reg.ctrl[CTRL_MODE_LSB+1];
  assign rx_clk_auto = st_reg.aux[AUX_AUTO_BIT];
  // with the automatic clock off the oscillator idles at its first code
  assign rx_clk_freq_sel = rx_clk_auto ? st_reg.ctrl[CTRL_FREQ_LSB+:2] : FREQ_50;
  assign datapath_control_second = st_reg.dp2;
  // open-drain scl: pulled low only during the low phase
  assign scl_o = 1'b0;
  assign scl_oe = st_reg.scl_active && st_reg.low_phase;
  assign sda_setup_wait = setup_busy;
  assign scl_release = setup_done;

  // assertion helpers: expected phase length and cycles counted per timer run
  function automatic int exp_cycles(input logic [7:0] len);
    int n;
    n = (int'(len) * UNIT_NS + CLK_NS - 1) / CLK_NS;
    return (n < 1) ? 1 : n;
  endfunction

  logic [7:0] scl_snap;
  logic [7:0] setup_snap;
  logic [15:0] scl_cyc;
  logic [15:0] setup_cyc;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_snap <= 8'h00;
      setup_snap <= 8'h00;
      scl_cyc <= 16'h0000;
      setup_cyc <= 16'h0000;
    end else if (ce) begin
      if (scl_start) begin
        scl_snap <= scl_len;
        scl_cyc <= 16'h0000;
      end else if (scl_busy) begin
        scl_cyc <= scl_cyc + 16'h0001;
      end
      if (setup_start) begin
        setup_snap <= st_reg.low_w;
        setup_cyc <= 16'h0000;
      end else if (setup_busy) begin
        setup_cyc <= setup_cyc + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_out_mode;
    ce && wr_go && wr_idx == IDX_CTRL[5:0] && st_reg.wstrb0 && st_reg.wdata[7:6] == MODE_ALT
      |=> out_toggle_alt && !out_toggle_data;
  endproperty
  a_out_mode: assert property (p_out_mode) else $error("alternating toggle mode not applied");

  property p_freq_sel;
    rx_clk_auto |-> rx_clk_freq_sel == st_reg.ctrl[5:4];
  endproperty
  a_freq_sel: assert property (p_freq_sel) else $error("oscillator frequency not taken from control");

  property p_pin_cfg;
    ce && !st_reg.ctrl[CTRL_PIN_BIT] && st_reg.ctrl[CTRL_EN_BIT] |-> selftest_active;
  endproperty
  a_pin_cfg: assert property (p_pin_cfg) else $error("register enable ignored in register mode");

  sequence s_enable_rise;
    ce && eff_en && !st_reg.en_prev && !st_reg.rw_valid;
  endsequence
  property p_remote_wr;
    s_enable_rise |=> remote_wr.valid && remote_wr.clk_src == $past(eff_cfg[2:1]) && remote_wr.addr == 8'h14;
  endproperty
  a_remote_wr: assert property (p_remote_wr) else $error("clock source not forwarded on enable");

  property p_ctrl_reset;
    sys_rst |=> st_reg.ctrl == 8'h08 && !out_toggle_alt;
  endproperty
  a_ctrl_reset: assert property (disable iff (1'b0) p_ctrl_reset) else $error("control reset value wrong");

  property p_err_read;
    ce && rd_go && rd_idx == IDX_ERR[5:0] |=> axi_rsp.rvalid && axi_rsp.rdata[7:0] == $past(st_reg.cnt[port_sel]);
  endproperty
  a_err_read: assert property (p_err_read) else $error("error count read from wrong port");

  property p_scl_high;
    ce && scl_done && st_reg.scl_active && !st_reg.low_phase |-> int'(scl_cyc) + 1 == exp_cycles(scl_snap);
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase length wrong");

  property p_scl_low;
    ce && scl_done && st_reg.scl_active && st_reg.low_phase |-> scl_oe && int'(scl_cyc) + 1 == exp_cycles(scl_snap);
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low phase length wrong");

  property p_sda_setup;
    ce && setup_done |-> int'(setup_cyc) + 1 == exp_cycles(setup_snap);
  endproperty
  a_sda_setup: assert property (p_sda_setup) else $error("sda setup time wrong");

  property p_default_margin;
    sys_rst |=> int'(st_reg.high_w) * UNIT_NS * NOM_OSC_MHZ >= MIN_SCL_NS * FAST_OSC_MHZ
      && int'(st_reg.low_w) * UNIT_NS * NOM_OSC_MHZ >= MIN_SCL_NS * FAST_OSC_MHZ;
  endproperty
  a_default_margin: assert property (disable iff (1'b0) p_default_margin)
    else $error("default scl counts too short");

  property p_count_hold;
    ce && !eff_en && !st_reg.en_prev |=> $stable(st_reg.cnt);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("error count moved while disabled");
endmodule

// file: verification/lst_remote_model.sv
// lst_remote_model: remote serializer end of the self-test settings write.
// assumes the write request comes from logic on mclk; slow holds ready off for three cycles.
module lst_remote_model
  import lst_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire lst_remote_wr_s remote_wr,
  input wire logic slow,
  output logic remote_wr_ready,
  output logic [1:0] clk_src_reg,
  output int writes
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  // ready is gated by valid, so a request is never taken before it is offered
  assign remote_wr_ready = remote_wr.valid && (!slow || wait_cnt >= 3);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wait_cnt <= 0;
      clk_src_reg <= 2'h0;
      writes <= 0;
    end else if (remote_wr.valid && remote_wr_ready) begin
      if (remote_wr.addr == REMOTE_CSRC_ADDR) clk_src_reg <= remote_wr.clk_src;
      writes <= writes + 1;
      wait_cnt <= 0;
    end else if (remote_wr.valid) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

// file: verification/test_lst_selftest_regs.sv
// test_lst_selftest_regs: self-checking bench for the self-test and scl timing register bank.
// assumes lst_pkg and the remote serializer model; one 10 MHz clock, axi4-lite driven here.
module test_lst_selftest_regs;
  timeunit 1ns;
  timeprecision 1ns;
  import lst_pkg::*;
  logic mclk, sys_rst, ce, irq, slow, i2c_ctl_en, scl_o, scl_oe, sda_setup_req, sda_setup_wait;
  logic scl_release, remote_wr_ready, selftest_active, out_toggle_alt, out_toggle_data, rx_clk_auto;
  logic [2:0] selftest_pin_cfg;
  logic [1:0] port_err, rx_clk_freq_sel, rsrc, r;
  logic [7:0] datapath_control_second, rnd, d, lo, hi;
  lst_axi_req_s req;
  lst_axi_rsp_s rsp;
  lst_remote_wr_s remote_wr;
  int err_count, tests_run, cyc, n, n0, n1, rwrites;
  logic [7:0] mdl [int];

  lst_selftest_regs #(.PORTS(2)) u_lst_selftest_regs (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .axi_req(req), .axi_rsp(rsp), .irq(irq), .selftest_pin_cfg(selftest_pin_cfg), .port_err(port_err),
    .remote_wr(remote_wr), .remote_wr_ready(remote_wr_ready), .selftest_active(selftest_active),
    .out_toggle_alt(out_toggle_alt), .out_toggle_data(out_toggle_data), .rx_clk_auto(rx_clk_auto),
    .rx_clk_freq_sel(rx_clk_freq_sel), .datapath_control_second(datapath_control_second),
    .i2c_ctl_en(i2c_ctl_en), .scl_o(scl_o), .scl_oe(scl_oe), .sda_setup_req(sda_setup_req),
    .sda_setup_wait(sda_setup_wait), .scl_release(scl_release));
  lst_remote_model u_lst_remote_model (.mclk(mclk), .sys_rst(sys_rst), .remote_wr(remote_wr),
    .slow(slow), .remote_wr_ready(remote_wr_ready), .clk_src_reg(rsrc), .writes(rwrites));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // bready and rready stay high throughout, so no strobe is lowered and raised in one step
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] v, output logic [1:0] resp);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    req.awaddr <= {idx[5:0], 2'h0};
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge mclk);
      if (!a && rsp.awready === 1'b1) begin
        a = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
  endtask

  task automatic bus_rd(input logic [7:0] idx, output logic [7:0] v, output logic [1:0] resp);
    req.araddr <= {idx[5:0], 2'h0};
    req.arvalid <= 1'b1;
    do @(posedge mclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge mclk); while (rsp.rvalid !== 1'b1);
    chk("rdata upper bits", 24'h0, rsp.rdata[31:8]);
    v = rsp.rdata[7:0];
    resp = rsp.rresp;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus_wr(idx, v, r);
    chk("bresp", RESP_OKAY, r);
    if (idx != IDX_ERR && idx != IDX_IST && idx != IDX_ICLR) mdl[idx] = v;
  endtask

  task automatic rd(input logic [7:0] idx);
    bus_rd(idx, d, r);
    chk("rresp", RESP_OKAY, r);
    chk($sformatf("register %h", idx), mdl[idx], d);
  endtask

  function automatic int span(input logic [7:0] len);
    return ((int'(len) * UNIT_NS + CLK_NS - 1) / CLK_NS);
  endfunction

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] run timed out after %0d cycles", cyc);
      wrap_up();
    end
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    slow = 1'b0;
    i2c_ctl_en = 1'b0;
    sda_setup_req = 1'b0;
    selftest_pin_cfg = 3'h0;
    port_err = 2'h0;
    rnd = 8'h3e;
    mdl[IDX_CTRL] = CTRL_RST;
    mdl[IDX_ERR] = 8'h00;
    mdl[IDX_HIGH] = HIGH_RST;
    mdl[IDX_LOW] = LOW_RST;
    mdl[IDX_DP2] = DP2_RST;
    mdl[IDX_AUX] = AUX_RST;
    mdl[IDX_IST] = 8'h00;
    mdl[IDX_IEN] = 8'h00;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (mdl[i]) rd(i[7:0]);
    // margin is judged on the counts the design really holds after reset
    bus_rd(IDX_HIGH, hi, r);
    bus_rd(IDX_LOW, lo, r);
    chk("default high at fast osc", 1, int'(hi) * UNIT_NS * NOM_OSC_MHZ / FAST_OSC_MHZ >= MIN_SCL_NS);
    chk("default low at fast osc", 1, int'(lo) * UNIT_NS * NOM_OSC_MHZ / FAST_OSC_MHZ >= MIN_SCL_NS);
    bus_rd(8'h29, d, r);
    chk("unmapped rresp", RESP_DECERR, r);
    chk("unmapped rdata", 8'h00, d);
    bus_wr(8'h29, 8'hff, r);
    chk("unmapped bresp", RESP_DECERR, r);
    wr(IDX_ERR, 8'h5a);
    rd(IDX_ERR);
    rnd = nx(rnd);
    wr(IDX_DP2, rnd);
    rd(IDX_DP2);
    chk("dp2 output", rnd, datapath_control_second);
    $display("reset and access test done");

    wr(IDX_AUX, 8'h20);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CTRL, {c[1:0], c[1:0], 4'h8});
      chk("toggle alternating", c == 1, out_toggle_alt);
      chk("toggle from data", c[1], out_toggle_data);
      chk("osc freq select", c[1:0], rx_clk_freq_sel);
      rd(IDX_CTRL);
    end
    wr(IDX_AUX, 8'h00);
    chk("freq when auto off", FREQ_50, rx_clk_freq_sel);
    chk("irq masked", 1'b0, irq);
    mdl[IDX_IST] = 8'h04;
    rd(IDX_IST);
    wr(IDX_IEN, 8'h04);
    chk("irq raised", 1'b1, irq);
    wr(IDX_ICLR, 8'h04);
    chk("irq cleared", 1'b0, irq);
    mdl[IDX_IST] = 8'h00;
    rd(IDX_IST);
    $display("mode and frequency test done");

    slow <= 1'b1;
    wr(IDX_IEN, 8'h01);
    rnd = nx(rnd);
    wr(IDX_CTRL, {5'h0, rnd[1:0], 1'b1});
    chk("active in register mode", 1'b1, selftest_active);
    n = 0;
    while (rwrites < 1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    chk("remote writes", 1, rwrites);
    chk("remote clock source", rnd[1:0], rsrc);
    @(posedge mclk);
    chk("irq on remote done", 1'b1, irq);
    wr(IDX_ICLR, 8'h01);
    slow <= 1'b0;
    rnd = nx(rnd);
    n0 = rnd[2:0] + 1;
    rnd = nx(rnd);
    n1 = rnd[2:0] + 1;
    for (int i = 0; i < 8; i++) begin
      port_err <= {i < n1, i < n0};
      @(posedge mclk);
    end
    port_err <= 2'h0;
    wr(IDX_CTRL, 8'h00);
    chk("inactive after disable", 1'b0, selftest_active);
    port_err <= 2'h3;
    repeat (3) @(posedge mclk);
    port_err <= 2'h0;
    mdl[IDX_ERR] = n0[7:0];
    rd(IDX_ERR);
    wr(IDX_AUX, 8'h01);
    mdl[IDX_ERR] = n1[7:0];
    rd(IDX_ERR);
    wr(IDX_CTRL, CTRL_RST);
    selftest_pin_cfg <= 3'h5;
    repeat (4) @(posedge mclk);
    chk("active from pin", 1'b1, selftest_active);
    selftest_pin_cfg <= 3'h0;
    repeat (4) @(posedge mclk);
    chk("inactive from pin", 1'b0, selftest_active);
    chk("remote source from pin", 2'h2, rsrc);
    $display("self-test enable and count test done");

    rnd = nx(rnd);
    hi = SCL_MIN + {4'h0, rnd[3:0]};
    lo = 8'h0b;
    wr(IDX_HIGH, hi);
    wr(IDX_LOW, lo);
    i2c_ctl_en <= 1'b1;
    n = 0;
    while (scl_oe !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (scl_oe === 1'b1 && n < 300) begin
        @(posedge mclk);
        n++;
      end
      chk("scl low cycles", span(lo), n);
      n = 0;
      while (scl_oe === 1'b0 && n < 300) begin
        @(posedge mclk);
        n++;
      end
      chk("scl high cycles", span(hi), n);
    end
    chk("scl drives low only", 1'b0, scl_o);
    i2c_ctl_en <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("scl released", 1'b0, scl_oe);
    sda_setup_req <= 1'b1;
    @(posedge mclk);
    sda_setup_req <= 1'b0;
    n = 0;
    while (scl_release !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("sda setup cycles", span(lo), n);
    $display("scl timing test done");
    wrap_up();
  end
endmodule
